// >>> design/cmrsc_ctrl.sv
// Common-mode, reference and shield drive control register with its decoded switch controls.
`timescale 1ns/1ps
`include "cmrsc_regs.svh"

module cmrsc_ctrl
  import cmrsc_pkg::*;
(
  input wire logic MCLK,
  input wire logic NRST,
  input wire logic [5:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic [23:0] REG_WDATA,
  output logic [23:0] REG_RDATA,
  output logic REG_HIT,
  output logic [4:0] CM_SWITCH,
  output logic [2:0] CM_COUNT,
  output logic CM_FROM_FIXED,
  output logic CM_FROM_EXTERNAL,
  output logic CM_PIN_DRIVE,
  output logic [5:0] DRIVE_SUM_SWITCH,
  output logic COMMON_ELECTRODE_REF_ENABLE,
  output logic [5:0] REF_DRIVE_ROUTE,
  output logic LEG_DRIVE_ENABLE,
  output logic SHIELD_DRIVE_ENABLE
);

  ////////////////////////////////////////////////////////////////////////////
  logic [23:0] ctl_r;
  logic [23:0] ctl_nxt;
  logic [2:0] sel_count;
  logic ext_cm;
  cmrsc_elec_t cm_sel;
  logic [3:0] ref_sel;
  logic [4:0] cm_switch_nxt;
  logic [2:0] cm_count_nxt;
  logic cm_fixed_nxt;
  logic cm_pin_nxt;
  logic [5:0] sum_sel;
  logic ce_ref_bit;
  logic leg_bit;
  logic shld_bit;
  cmrsc_ref_e ref_code;
  logic [5:0] route_nxt;

  assign REG_HIT = (REG_ADDR == `CMRSC_ADDR);

  assign ctl_nxt = REG_WDATA & `CMRSC_WMASK;

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      ctl_r <= `CMRSC_RESET;
    end else if (REG_WR && REG_HIT) begin
      ctl_r <= ctl_nxt;
    end
  end

  // Read data is a flop so the serial shifter sees a stable word.
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      REG_RDATA <= `CMRSC_RDATA_RESET;
    end else if (REG_HIT) begin
      REG_RDATA <= ctl_r;
    end else begin
      REG_RDATA <= 24'h000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign ext_cm = ctl_r[`CMRSC_EXT_BIT];
  assign cm_sel = ctl_r[`CMRSC_CM_SEL_HI:`CMRSC_CM_SEL_LO];
  assign ref_sel = ctl_r[`CMRSC_REFSEL_HI:`CMRSC_REFSEL_LO];
  assign sum_sel = ctl_r[`CMRSC_SUM_HI:`CMRSC_SUM_LO];
  assign ce_ref_bit = ctl_r[`CMRSC_CE_EN_BIT];
  assign leg_bit = ctl_r[`CMRSC_LEG_BIT];
  assign shld_bit = ctl_r[`CMRSC_SHLD_BIT];

  cmrsc_count u_count (
    .sel(cm_sel),
    .count(sel_count)
  );

  always_comb begin
    if (ext_cm) begin
      cm_switch_nxt = 5'h00;
      cm_count_nxt = 3'h0;
    end else begin
      cm_switch_nxt = cm_sel;
      cm_count_nxt = sel_count;
    end
  end

  assign cm_fixed_nxt = !ext_cm && (cm_sel == 5'h00);

  assign cm_pin_nxt = ctl_r[`CMRSC_COMMON_MODE_PIN_DRIVE_BIT] && !ext_cm;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      CM_SWITCH <= `CMRSC_SWITCH_RESET;
    end else begin
      CM_SWITCH <= cm_switch_nxt;
    end
  end

  // A zero divisor only occurs while the fixed or external level is in use, so the averager idles.
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      CM_COUNT <= `CMRSC_COUNT_RESET;
    end else begin
      CM_COUNT <= cm_count_nxt;
    end
  end

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      CM_FROM_EXTERNAL <= 1'b0;
    end else begin
      CM_FROM_EXTERNAL <= ext_cm;
    end
  end

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      CM_FROM_FIXED <= 1'b0;
    end else begin
      CM_FROM_FIXED <= cm_fixed_nxt;
    end
  end

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      CM_PIN_DRIVE <= 1'b0;
    end else begin
      CM_PIN_DRIVE <= cm_pin_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // summing switches
  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      DRIVE_SUM_SWITCH <= 6'h00;
    end else begin
      DRIVE_SUM_SWITCH <= sum_sel;
    end
  end

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      COMMON_ELECTRODE_REF_ENABLE <= 1'b0;
    end else begin
      COMMON_ELECTRODE_REF_ENABLE <= ce_ref_bit;
    end
  end

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      LEG_DRIVE_ENABLE <= 1'b0;
    end else begin
      LEG_DRIVE_ENABLE <= leg_bit;
    end
  end

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      SHIELD_DRIVE_ENABLE <= 1'b0;
    end else begin
      SHIELD_DRIVE_ENABLE <= shld_bit;
    end
  end

  always_comb begin
    if (ref_sel > `CMRSC_REFSEL_MAX) begin
      ref_code = CMRSC_REF_NONE;
    end else begin
      ref_code = cmrsc_ref_e'(ref_sel);
    end
  end

  // Reserved codes route nowhere rather than guess a safe electrode.
  always_comb begin
    case (ref_code)
      CMRSC_REF_DRIVE_PIN: route_nxt = 6'h01;
      CMRSC_REF_LA: route_nxt = 6'h02;
      CMRSC_REF_LL: route_nxt = 6'h04;
      CMRSC_REF_RA: route_nxt = 6'h08;
      CMRSC_REF_V1: route_nxt = 6'h10;
      CMRSC_REF_V2: route_nxt = 6'h20;
      default: route_nxt = 6'h00;
    endcase
  end

  always_ff @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      REF_DRIVE_ROUTE <= `CMRSC_ROUTE_RESET;
    end else begin
      REF_DRIVE_ROUTE <= route_nxt;
    end
  end

endmodule

// >>> design/cmrsc_regs.svh
// Register offsets, field positions, reset values and codes of the common-mode control register.
`ifndef CMRSC_REGS_SVH
`define CMRSC_REGS_SVH
`define CMRSC_ADDR 6'h05
`define CMRSC_RESET 24'he00000
`define CMRSC_RDATA_RESET 24'h000000
`define CMRSC_SWITCH_RESET 5'h1c
`define CMRSC_COUNT_RESET 3'h3
`define CMRSC_ROUTE_RESET 6'h01
`define CMRSC_CM_SEL_HI 23
`define CMRSC_CM_SEL_LO 19
`define CMRSC_RSVD_HI 18
`define CMRSC_RSVD_LO 15
`define CMRSC_SUM_HI 14
`define CMRSC_SUM_LO 9
`define CMRSC_CE_EN_BIT 8
`define CMRSC_REFSEL_HI 7
`define CMRSC_REFSEL_LO 4
`define CMRSC_COMMON_MODE_PIN_DRIVE_BIT 3
`define CMRSC_EXT_BIT 2
`define CMRSC_LEG_BIT 1
`define CMRSC_SHLD_BIT 0
`define CMRSC_WMASK 24'hf87fff
`define CMRSC_REFSEL_MAX 4'h5
`define CMRSC_FIXED_LEVEL_MV 16'h0514
`endif

// >>> design/cmrsc_pkg.sv
// Types shared by the common-mode control register files.
package cmrsc_pkg;
  typedef enum logic [3:0] {
    CMRSC_REF_DRIVE_PIN,
    CMRSC_REF_LA,
    CMRSC_REF_LL,
    CMRSC_REF_RA,
    CMRSC_REF_V1,
    CMRSC_REF_V2,
    CMRSC_REF_NONE
  } cmrsc_ref_e;
  typedef logic [4:0] cmrsc_elec_t;
endpackage

// >>> design/cmrsc_count.sv
// Population count of the five common-mode electrode selects.
`timescale 1ns/1ps
module cmrsc_count
  import cmrsc_pkg::*;
(
  input wire cmrsc_elec_t sel,
  output logic [2:0] count
);
  always_comb begin
    count = 3'h0;
    for (int i = 0; i < 5; i++) begin
      count = count + {2'h0, sel[i]};
    end
  end
endmodule

// >>> test/cmrsc_ctrl_sva.sv
// Port checks of the common-mode control register.
`timescale 1ns/1ps
module cmrsc_ctrl_sva (
  input logic MCLK,
  input logic NRST,
  input logic [5:0] REG_ADDR,
  input logic [23:0] REG_RDATA,
  input logic REG_HIT,
  input logic [4:0] CM_SWITCH,
  input logic [2:0] CM_COUNT,
  input logic CM_FROM_FIXED,
  input logic CM_FROM_EXTERNAL,
  input logic CM_PIN_DRIVE,
  input logic [5:0] DRIVE_SUM_SWITCH,
  input logic COMMON_ELECTRODE_REF_ENABLE,
  input logic [5:0] REF_DRIVE_ROUTE,
  input logic LEG_DRIVE_ENABLE,
  input logic SHIELD_DRIVE_ENABLE
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!NRST);
  // Read word and decodes load from one register, so they agree one edge after a read.
  logic rd_r;
  always_ff @(posedge MCLK or negedge NRST)
    if (!NRST) rd_r <= 1'b0;
    else rd_r <= REG_ADDR == 6'h05;
  AST_CM_SEL: assert property (rd_r |-> CM_FROM_EXTERNAL == REG_RDATA[2] &&
    CM_SWITCH == (REG_RDATA[2] ? 5'h00 : REG_RDATA[23:19])) else $error("cm select");
  AST_CM_AVG: assert property (CM_COUNT == $countones(CM_SWITCH)) else $error("divisor");
  AST_CM_FIX: assert property (rd_r |-> CM_FROM_FIXED ==
    (REG_RDATA[23:19] == 5'h00 && !REG_RDATA[2])) else $error("fixed level");
  AST_CM_PIN: assert property (rd_r |-> CM_PIN_DRIVE ==
    (REG_RDATA[3] && !REG_RDATA[2])) else $error("cm pin");
  AST_SUM_CE: assert property (rd_r |->
    {DRIVE_SUM_SWITCH, COMMON_ELECTRODE_REF_ENABLE} == REG_RDATA[14:8]) else $error("sum");
  AST_ROUTE: assert property (rd_r |-> REF_DRIVE_ROUTE ==
    (REG_RDATA[7:4] > 4'h5 ? 6'h00 : 6'h01 << REG_RDATA[7:4])) else $error("route");
  AST_ENABLES: assert property (rd_r |->
    {LEG_DRIVE_ENABLE, SHIELD_DRIVE_ENABLE} == REG_RDATA[1:0]) else $error("enables");
  AST_RSVD: assert property (REG_HIT |=> REG_RDATA[18:15] == 4'h0) else $error("reserved");
  AST_ADDR: assert property (REG_HIT == (REG_ADDR == 6'h05) &&
    (rd_r || REG_RDATA == 24'h000000)) else $error("address");
endmodule
bind cmrsc_ctrl cmrsc_ctrl_sva u_cmrsc_ctrl_sva (
  .MCLK(MCLK),
  .NRST(NRST),
  .REG_ADDR(REG_ADDR),
  .REG_RDATA(REG_RDATA),
  .REG_HIT(REG_HIT),
  .CM_SWITCH(CM_SWITCH),
  .CM_COUNT(CM_COUNT),
  .CM_FROM_FIXED(CM_FROM_FIXED),
  .CM_FROM_EXTERNAL(CM_FROM_EXTERNAL),
  .CM_PIN_DRIVE(CM_PIN_DRIVE),
  .DRIVE_SUM_SWITCH(DRIVE_SUM_SWITCH),
  .COMMON_ELECTRODE_REF_ENABLE(COMMON_ELECTRODE_REF_ENABLE),
  .REF_DRIVE_ROUTE(REF_DRIVE_ROUTE),
  .LEG_DRIVE_ENABLE(LEG_DRIVE_ENABLE),
  .SHIELD_DRIVE_ENABLE(SHIELD_DRIVE_ENABLE)
);

// >>> test/testbench.sv
// Random and corner-case testbench of the common-mode control register.
`timescale 1ns/1ps
module testbench;
  logic MCLK = 1'b0;
  logic NRST = 1'b0;
  logic REG_WR = 1'b0;
  logic [5:0] REG_ADDR = 6'h00;
  logic [23:0] REG_WDATA = 24'h000000;
  logic [23:0] REG_RDATA, m, v;
  logic REG_HIT, CM_FROM_FIXED, CM_FROM_EXTERNAL, CM_PIN_DRIVE, COMMON_ELECTRODE_REF_ENABLE;
  logic LEG_DRIVE_ENABLE, SHIELD_DRIVE_ENABLE;
  logic [4:0] CM_SWITCH;
  logic [2:0] CM_COUNT;
  logic [5:0] DRIVE_SUM_SWITCH, REF_DRIVE_ROUTE;
  int errors = 0;
  int num_checks = 0;
  cmrsc_ctrl u_cmrsc_ctrl (
    .MCLK(MCLK),
    .NRST(NRST),
    .REG_ADDR(REG_ADDR),
    .REG_WR(REG_WR),
    .REG_WDATA(REG_WDATA),
    .REG_RDATA(REG_RDATA),
    .REG_HIT(REG_HIT),
    .CM_SWITCH(CM_SWITCH),
    .CM_COUNT(CM_COUNT),
    .CM_FROM_FIXED(CM_FROM_FIXED),
    .CM_FROM_EXTERNAL(CM_FROM_EXTERNAL),
    .CM_PIN_DRIVE(CM_PIN_DRIVE),
    .DRIVE_SUM_SWITCH(DRIVE_SUM_SWITCH),
    .COMMON_ELECTRODE_REF_ENABLE(COMMON_ELECTRODE_REF_ENABLE),
    .REF_DRIVE_ROUTE(REF_DRIVE_ROUTE),
    .LEG_DRIVE_ENABLE(LEG_DRIVE_ENABLE),
    .SHIELD_DRIVE_ENABLE(SHIELD_DRIVE_ENABLE)
  );
  always #10 MCLK = ~MCLK;
  function automatic logic [25:0] want(logic [23:0] r);
    logic [4:0] sw;
    sw = r[2] ? 5'h00 : r[23:19];
    return {sw, 3'($countones(sw)), !r[2] && r[23:19] == 5'h00, r[2], r[3] && !r[2], r[14:8],
      (r[7:4] > 4'h5 ? 6'h00 : 6'h01 << r[7:4]), r[1:0]};
  endfunction
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [23:0] d);
    @(negedge MCLK);
    REG_ADDR = a;
    REG_WR = 1'b1;
    REG_WDATA = d;
    if (a == 6'h05) m = d & 24'hf87fff;
  endtask
  // Other addresses read as zero, since the read mux lives outside.
  task automatic rd(input logic [5:0] a);
    @(negedge MCLK);
    REG_WR = 1'b0;
    REG_ADDR = a;
    repeat (2) @(negedge MCLK);
    chk({REG_HIT, REG_RDATA, CM_SWITCH, CM_COUNT, CM_FROM_FIXED, CM_FROM_EXTERNAL,
      CM_PIN_DRIVE, DRIVE_SUM_SWITCH, COMMON_ELECTRODE_REF_ENABLE, REF_DRIVE_ROUTE,
      LEG_DRIVE_ENABLE, SHIELD_DRIVE_ENABLE}, {a == 6'h05, a == 6'h05 ? m : 24'h000000, want(m)});
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    void'($urandom(32'h7b04));
    repeat (6) @(posedge MCLK);
    @(negedge MCLK);
    NRST = 1'b1;
    m = 24'he00000;
    rd(6'h05);
    wr(6'h06, 24'h1f0fff);
    rd(6'h06);
    rd(6'h05);
    for (int i = 0; i < 40; i++) begin
      v = i == 0 ? 24'hffffff : i == 2 ? 24'h00000c : i == 4 ? 24'h000008 :
        i == 6 ? 24'h80000b : 24'($urandom);
      if (i > 2 && i < 19) v[7:4] = 4'(i - 3);
      wr(6'h05, v);
      if (i[0]) wr(6'h05, ~v);
      rd(6'h05);
    end
    // Switches stay closed with the leg drive off until software clears them.
    wr(6'h05, 24'h007e02);
    rd(6'h05);
    wr(6'h05, 24'h007e00);
    rd(6'h05);
    wr(6'h05, 24'h000000);
    rd(6'h05);
    // A second reset in mid-run must bring back the default selects.
    @(negedge MCLK);
    NRST = 1'b0;
    REG_ADDR = 6'h00;
    repeat (2) @(negedge MCLK);
    chk({REG_RDATA, CM_SWITCH, CM_COUNT, REF_DRIVE_ROUTE}, {24'h000000, 5'h1c, 3'h3, 6'h01});
    NRST = 1'b1;
    m = 24'he00000;
    rd(6'h05);
    conclude;
  end
  initial begin
    #20000;
    errors++;
    conclude;
  end
endmodule
